// [rtl/adcc_pkg.sv]
`default_nettype none
package adcc_pkg;

  // result and channel widths
  localparam int unsigned RESULT_W     = 12;
  localparam int unsigned CHAN_W       = 4;
  localparam int unsigned BYTE_W       = 8;
  localparam int unsigned BIT_IDX_W    = 4;
  localparam int unsigned CHAN_LARGE   = 13;
  localparam int unsigned CHAN_SMALL   = 10;

  // apb byte addresses, one aligned word each
  localparam logic [7:0] ADDR_CONTROL  = 8'h00;
  localparam logic [7:0] ADDR_PIN_CFG  = 8'h04;
  localparam logic [7:0] ADDR_TIM_CFG  = 8'h08;
  localparam logic [7:0] ADDR_RES_HIGH = 8'h0C;
  localparam logic [7:0] ADDR_RES_LOW  = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;

  // conversion_control_reg fields
  localparam int unsigned CTL_EN_BIT   = 0;
  localparam int unsigned CTL_GO_BIT   = 1;
  localparam int unsigned CTL_CHS_LSB  = 2;
  localparam logic [7:0]  CTL_RESET    = 8'h00;

  // pin_function_config_reg fields
  localparam int unsigned PIN_PORT_LSB = 0;
  localparam int unsigned PIN_PORT_W   = 4;
  localparam int unsigned PIN_VHI_BIT  = 4;
  localparam int unsigned PIN_VLO_BIT  = 5;
  localparam logic [7:0]  PIN_WMASK    = 8'h3F;

  // timing_format_config_reg fields
  localparam int unsigned TIM_DIV_LSB  = 0;
  localparam int unsigned TIM_DIV_W    = 3;
  localparam int unsigned TIM_ACQ_LSB  = 3;
  localparam int unsigned TIM_ACQ_W    = 3;
  localparam int unsigned TIM_RJ_BIT   = 7;
  localparam logic [7:0]  TIM_WMASK    = 8'hBF;

  // interrupt bits
  localparam int unsigned IRQ_W        = 2;
  localparam int unsigned IRQ_DONE_BIT = 0;
  localparam int unsigned IRQ_ABRT_BIT = 1;

  // conversion clock: period is DIV_BASE ref clocks shifted by the divider field
  localparam int unsigned DIV_CNT_W    = 11;
  localparam logic [DIV_CNT_W-1:0] DIV_BASE = 11'h008;
  localparam logic [3:0] ACQ_MIN_TICKS = 4'h1;

  // last implemented channel code, and the codes the small variant leaves empty
  localparam logic [3:0] CHS_LAST_IMPL = 4'hC;
  localparam logic [3:0] CHS_GAP_LO    = 4'h5;
  localparam logic [3:0] CHS_GAP_HI    = 4'h7;

  typedef enum logic [1:0] {
    ADCC_IDLE = 2'b00,
    ADCC_ACQ  = 2'b01,
    ADCC_CONV = 2'b10
  } adcc_state_t;

endpackage
`default_nettype wire

// [rtl/adcc_pin_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module adcc_pin_sync (
  // clock and reset
  input  wire logic ref_clk_i,
  input  wire logic rst_i,
  // asynchronous pin and its filtered level
  input  wire logic pin_i,
  output logic      level_o
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
  } adcc_sync_t;

  adcc_sync_t st_reg;
  adcc_sync_t st_next;

  // s1 feeds only s2; level moves once s2 and s3 agree
  always_comb
  begin
    st_next    = st_reg;
    st_next.s1 = pin_i;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    if (st_reg.s2 == st_reg.s3)
    begin
      st_next.level = st_reg.s3;
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign level_o = st_reg.level;

endmodule
`default_nettype wire

// [rtl/adcc_top.sv]
// Notes on behaviour
// (R1) Each conversion yields an unsigned 12-bit code by successive approximation.
// (R2) The result is presented in a high result byte and a low result byte.
// (R3) The large variant offers 13 analog inputs, the small variant 10.
// (R4) Control bits 5:2 select the channel, codes 0 to 12 being channels 0 to 12.
// (R5) Codes 13 to 15 have no input, so a conversion there reads a floating input.
// (R6) On the small variant codes 5 to 7 are unimplemented like codes 13 to 15.
// (R7) Control bit 1 reads 1 while converting and 0 when idle, with the converter on.
// (R8) Control bit 0 turns the converter on when 1 and off when 0.
// (R9) Control bits 7:6 always read 0 and ignore writes.
// (R10) A timing register sets conversion clock, acquisition time and justification.
// (R11) Software picks the upper reference from a pin or supply, the lower from pin or ground.
// (R12) Writing 1 to bit 1 while enabled starts a conversion; hardware clears it when done.
// (R13) Writable control bits reset to 0: converter off, idle, channel 0.
//
// The APB slave port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
module adcc_top #(
  parameter bit LARGE_VARIANT = 1'b1
) (
  // clock and reset
  input  wire logic                         ref_clk_i,
  input  wire logic                         rst_i,
  // apb slave
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [7:0]                   paddr,
  input  wire logic [31:0]                  pwdata,
  input  wire logic [3:0]                   pstrb,
  output logic [31:0]                       prdata,
  output logic                              pready,
  output logic                              pslverr,
  // analog front end
  input  wire logic                         comp_i,
  output logic [adcc_pkg::RESULT_W-1:0]     dac_code_o,
  output logic                              sample_o,
  output logic [adcc_pkg::CHAN_W-1:0]       input_channel_select_o,
  output logic                              channel_valid_o,
  output logic                              converter_enable_o,
  output logic                              upper_ref_pin_o,
  output logic                              lower_ref_pin_o,
  output logic [adcc_pkg::PIN_PORT_W-1:0]   port_config_o,
  // interrupt
  output logic                              irq_o
);

  typedef struct packed {
    logic                               enable;
    logic [adcc_pkg::CHAN_W-1:0]        chs;
    logic [7:0]                         pin_cfg;
    logic [7:0]                         tim_cfg;
    logic [7:0]                         res_high;
    logic [7:0]                         res_low;
    logic [adcc_pkg::IRQ_W-1:0]         irq_stat;
    logic [adcc_pkg::IRQ_W-1:0]         irq_mask;
    adcc_pkg::adcc_state_t              state;
    logic [adcc_pkg::DIV_CNT_W-1:0]     div_cnt;
    logic [3:0]                         acq_cnt;
    logic [adcc_pkg::BIT_IDX_W-1:0]     bit_idx;
    logic [adcc_pkg::RESULT_W-1:0]      sar;
    logic [31:0]                        rdata;
    logic                               err;
  } adcc_regs_t;

  adcc_regs_t st_reg;
  adcc_regs_t st_next;

  logic comp_level;

  // comparator is asynchronous to the bus clock, so it is filtered before use
  adcc_pin_sync u_comp_sync (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .pin_i     (comp_i),
    .level_o   (comp_level)
  );

  localparam int unsigned TIM_ACQ_W_L = adcc_pkg::TIM_ACQ_W;

  // decode helpers
  logic                              setup_phase;
  logic                              access_phase;
  logic                              wr_access;
  logic                              rd_access;
  logic                              addr_hit;
  logic                              busy;
  logic                              chan_impl;
  logic                              tick;
  logic [adcc_pkg::DIV_CNT_W-1:0]    div_period;
  logic [3:0]                        acq_ticks;
  logic [TIM_ACQ_W_L-1:0]            acq_field;
  logic [7:0]                        ctl_read;
  logic [7:0]                        wbyte;
  logic                              wr_ctl;
  logic                              start_req;
  logic                              done_evt;
  logic                              abort_evt;
  logic [adcc_pkg::RESULT_W-1:0]     sar_kept;
  logic [adcc_pkg::RESULT_W-1:0]     one_hot_next;

  assign setup_phase  = psel & ~penable;
  assign access_phase = psel & penable;
  assign wr_access    = access_phase & pwrite & ~st_reg.err;
  assign rd_access    = access_phase & ~pwrite & ~st_reg.err;
  assign wbyte        = pstrb[0] ? pwdata[7:0] : 8'h00;
  assign busy         = (st_reg.state != adcc_pkg::ADCC_IDLE);

  always_comb
  begin
    unique case (paddr)
      adcc_pkg::ADDR_CONTROL,
      adcc_pkg::ADDR_PIN_CFG,
      adcc_pkg::ADDR_TIM_CFG,
      adcc_pkg::ADDR_RES_HIGH,
      adcc_pkg::ADDR_RES_LOW,
      adcc_pkg::ADDR_IRQ_STAT,
      adcc_pkg::ADDR_IRQ_MASK: addr_hit = 1'b1;
      default:                 addr_hit = 1'b0;
    endcase
  end

  // an empty code still converts; only channel_valid_o warns the front end
  // (R3) channel count follows the variant
  // (R5) codes above the last channel are empty
  // (R6) small variant also loses codes 5 to 7
  always_comb
  begin
    chan_impl = (st_reg.chs <= adcc_pkg::CHS_LAST_IMPL);
    if (!LARGE_VARIANT && (st_reg.chs >= adcc_pkg::CHS_GAP_LO)
        && (st_reg.chs <= adcc_pkg::CHS_GAP_HI))
    begin
      chan_impl = 1'b0;
    end
  end

  // (R9) top bits read zero
  // (R7) busy flag visible on bit 1
  always_comb
  begin
    ctl_read                                          = 8'h00;
    ctl_read[adcc_pkg::CTL_EN_BIT]                    = st_reg.enable;
    ctl_read[adcc_pkg::CTL_GO_BIT]                    = busy;
    ctl_read[adcc_pkg::CTL_CHS_LSB +: adcc_pkg::CHAN_W] = st_reg.chs;
  end

  // (R10) conversion clock divider and acquisition length from timing register
  assign div_period = adcc_pkg::DIV_BASE
                      << st_reg.tim_cfg[adcc_pkg::TIM_DIV_LSB +: adcc_pkg::TIM_DIV_W];
  // tick closes each conversion clock period; the counter rests at zero when idle
  assign tick       = (st_reg.div_cnt == div_period - adcc_pkg::DIV_BASE / adcc_pkg::DIV_BASE);
  assign acq_field  = st_reg.tim_cfg[adcc_pkg::TIM_ACQ_LSB +: adcc_pkg::TIM_ACQ_W];
  // acquisition is twice the field in ticks, never shorter than one tick
  assign acq_ticks  = (acq_field == '0) ? adcc_pkg::ACQ_MIN_TICKS : {acq_field, 1'b0};

  // (R12) start needs the enable bit set in the written value
  assign wr_ctl    = wr_access & (paddr == adcc_pkg::ADDR_CONTROL);
  assign start_req = wr_ctl & wbyte[adcc_pkg::CTL_GO_BIT] & wbyte[adcc_pkg::CTL_EN_BIT]
                     & ~busy;

  // each trial waits a full tick, which covers the comparator filter latency
  // (R1) successive approximation: keep the trial bit if the input is at or above it
  always_comb
  begin
    sar_kept     = st_reg.sar;
    one_hot_next = '0;
    if (!comp_level)
    begin
      sar_kept[st_reg.bit_idx] = 1'b0;
    end
    if (st_reg.bit_idx != '0)
    begin
      one_hot_next[st_reg.bit_idx - 4'h1] = 1'b1;
    end
  end

  // no done flag once enable has dropped, so an abandoned run never reports
  assign done_evt  = (st_reg.state == adcc_pkg::ADCC_CONV) & tick & (st_reg.bit_idx == '0)
                     & st_reg.enable;
  // abort shows one cycle after the disabling write, while the state is still busy
  assign abort_evt = busy & ~st_reg.enable;

  always_comb
  begin
    st_next = st_reg;

    // register writes take effect at the access edge
    if (wr_ctl)
    begin
      // (R8) enable bit
      st_next.enable = wbyte[adcc_pkg::CTL_EN_BIT];
      // (R4) channel field in bits 5:2
      st_next.chs    = wbyte[adcc_pkg::CTL_CHS_LSB +: adcc_pkg::CHAN_W];
    end
    if (wr_access && paddr == adcc_pkg::ADDR_PIN_CFG)
    begin
      // (R11) reference source selects
      st_next.pin_cfg = wbyte & adcc_pkg::PIN_WMASK;
    end
    if (wr_access && paddr == adcc_pkg::ADDR_TIM_CFG)
    begin
      st_next.tim_cfg = wbyte & adcc_pkg::TIM_WMASK;
    end
    if (wr_access && paddr == adcc_pkg::ADDR_IRQ_MASK)
    begin
      st_next.irq_mask = wbyte[adcc_pkg::IRQ_W-1:0];
    end

    // conversion clock runs only while a conversion is under way
    if (busy && !tick)
    begin
      st_next.div_cnt = st_reg.div_cnt + 11'h001;
    end
    else
    begin
      st_next.div_cnt = '0;
    end

    unique case (st_reg.state)
      adcc_pkg::ADCC_IDLE:
      begin
        if (start_req)
        begin
          st_next.state   = adcc_pkg::ADCC_ACQ;
          st_next.acq_cnt = acq_ticks;
        end
      end
      adcc_pkg::ADCC_ACQ:
      begin
        if (tick)
        begin
          st_next.acq_cnt = st_reg.acq_cnt - 4'h1;
          if (st_reg.acq_cnt == adcc_pkg::ACQ_MIN_TICKS)
          begin
            st_next.state   = adcc_pkg::ADCC_CONV;
            st_next.bit_idx = 4'(adcc_pkg::RESULT_W - 1);
            st_next.sar     = 12'h800;
          end
        end
      end
      adcc_pkg::ADCC_CONV:
      begin
        if (tick)
        begin
          st_next.sar     = sar_kept | one_hot_next;
          st_next.bit_idx = st_reg.bit_idx - 4'h1;
          if (st_reg.bit_idx == '0)
          begin
            // (R12) hardware clears busy once results are stored
            st_next.state = adcc_pkg::ADCC_IDLE;
            // (R2) store into the two result bytes with the chosen justification
            if (st_reg.tim_cfg[adcc_pkg::TIM_RJ_BIT])
            begin
              st_next.res_high = {4'h0, sar_kept[11:8]};
              st_next.res_low  = sar_kept[7:0];
            end
            else
            begin
              st_next.res_high = sar_kept[11:4];
              st_next.res_low  = {sar_kept[3:0], 4'h0};
            end
          end
        end
      end
      default:
      begin
        st_next.state = adcc_pkg::ADCC_IDLE;
      end
    endcase

    // (R8) turning the converter off abandons any conversion
    // a start in the same write that sets enable must not be lost to the old value
    if (!st_reg.enable && !start_req)
    begin
      st_next.state = adcc_pkg::ADCC_IDLE;
    end

    // sticky status: read clears, a new event in the same cycle wins
    // only bits the read returned are cleared; one set after the setup cycle stays
    if (rd_access && paddr == adcc_pkg::ADDR_IRQ_STAT)
    begin
      st_next.irq_stat = st_reg.irq_stat & ~st_reg.rdata[adcc_pkg::IRQ_W-1:0];
    end
    if (done_evt)
    begin
      st_next.irq_stat[adcc_pkg::IRQ_DONE_BIT] = 1'b1;
    end
    if (abort_evt)
    begin
      st_next.irq_stat[adcc_pkg::IRQ_ABRT_BIT] = 1'b1;
    end

    // read data and error captured in the setup cycle, zero wait access
    if (setup_phase)
    begin
      st_next.err   = ~addr_hit;
      st_next.rdata = 32'h0000_0000;
      unique case (paddr)
        adcc_pkg::ADDR_CONTROL:  st_next.rdata[7:0] = ctl_read;
        adcc_pkg::ADDR_PIN_CFG:  st_next.rdata[7:0] = st_reg.pin_cfg;
        adcc_pkg::ADDR_TIM_CFG:  st_next.rdata[7:0] = st_reg.tim_cfg;
        adcc_pkg::ADDR_RES_HIGH: st_next.rdata[7:0] = st_reg.res_high;
        adcc_pkg::ADDR_RES_LOW:  st_next.rdata[7:0] = st_reg.res_low;
        adcc_pkg::ADDR_IRQ_STAT: st_next.rdata[adcc_pkg::IRQ_W-1:0] = st_reg.irq_stat;
        adcc_pkg::ADDR_IRQ_MASK: st_next.rdata[adcc_pkg::IRQ_W-1:0] = st_reg.irq_mask;
        default:                 st_next.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      // (R13) everything clears: off, idle, channel 0
      st_reg         <= '0;
      st_reg.state   <= adcc_pkg::ADCC_IDLE;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // apb answer: ready in the first access cycle
  // read data is taken in the setup cycle, so no wait state is ever needed
  assign pready  = access_phase;
  assign pslverr = access_phase & st_reg.err;
  assign prdata  = st_reg.rdata;

  // analog front end drive
  assign dac_code_o             = st_reg.sar;
  assign sample_o               = (st_reg.state == adcc_pkg::ADCC_ACQ);
  assign input_channel_select_o = st_reg.chs;
  // (R5) an empty code leaves the mux open so the comparator sees a floating node
  assign channel_valid_o        = chan_impl & st_reg.enable;
  assign converter_enable_o     = st_reg.enable;
  // (R11) reference routing
  assign upper_ref_pin_o        = st_reg.pin_cfg[adcc_pkg::PIN_VHI_BIT];
  assign lower_ref_pin_o        = st_reg.pin_cfg[adcc_pkg::PIN_VLO_BIT];
  assign port_config_o          = st_reg.pin_cfg[adcc_pkg::PIN_PORT_LSB +: adcc_pkg::PIN_PORT_W];

  assign irq_o = |(st_reg.irq_stat & st_reg.irq_mask);

endmodule
`default_nettype wire

// [bench/adcc_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module adcc_properties #(
  parameter bit LARGE_VARIANT = 1'b1
) (
  input wire logic        ref_clk_i,
  input wire logic        rst_i,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        sample_o,
  input wire logic [3:0]  input_channel_select_o,
  input wire logic        channel_valid_o,
  input wire logic        converter_enable_o,
  input wire logic        upper_ref_pin_o,
  input wire logic        lower_ref_pin_o,
  input wire logic [3:0]  port_config_o,
  input wire logic        irq_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  a_top_bits_zero: assert property (psel && penable && !pwrite && paddr == 8'h00
    |-> prdata[7:6] == 2'h0) else $error("control bits 7:6 read nonzero");
  a_enable_written: assert property (psel && penable && pwrite && paddr == 8'h00
    && pstrb[0] |=> converter_enable_o == $past(pwdata[0])) else $error("enable not written");
  a_channel_written: assert property (psel && penable && pwrite && paddr == 8'h00
    && pstrb[0] |=> input_channel_select_o == $past(pwdata[5:2]))
    else $error("channel not written");
  a_channel_valid: assert property ($stable(input_channel_select_o)
    && $stable(converter_enable_o) |-> channel_valid_o == (converter_enable_o
    && input_channel_select_o <= 4'hC && (LARGE_VARIANT || input_channel_select_o < 4'h5
    || input_channel_select_o > 4'h7))) else $error("channel valid wrong");
  a_ref_select: assert property (psel && penable && pwrite && paddr == 8'h04 && pstrb[0]
    |=> {lower_ref_pin_o, upper_ref_pin_o, port_config_o} == $past(pwdata[5:0]))
    else $error("reference select not written");
  a_reset_clean: assert property ($fell(rst_i) |-> !converter_enable_o && !irq_o
    && !sample_o && input_channel_select_o == 4'h0) else $error("state not cleared by reset");
  a_off_no_sample: assert property (!converter_enable_o && !$past(converter_enable_o)
    |-> !sample_o) else $error("sampling while disabled");
  a_unmapped_error: assert property (psel && penable && paddr > 8'h18 |-> pslverr)
    else $error("unmapped access without error");
endmodule
bind adcc_top adcc_properties #(.LARGE_VARIANT(LARGE_VARIANT)) u_props (.ref_clk_i, .rst_i,
  .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pslverr, .sample_o,
  .input_channel_select_o, .channel_valid_o, .converter_enable_o, .upper_ref_pin_o,
  .lower_ref_pin_o, .port_config_o, .irq_o);
`default_nettype wire

// [bench/adc_conversion_control_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_control_tb;
  logic        ref_clk_i = 1'b0;
  logic        rst_i     = 1'b1;
  logic        psel      = 1'b0;
  logic        penable   = 1'b0;
  logic        pwrite    = 1'b0;
  logic [7:0]  paddr     = 8'h00;
  logic [31:0] pwdata    = 32'h0;
  logic [3:0]  pstrb     = 4'hF;
  logic        comp_i    = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [11:0] dac_code_o;
  logic        sample_o;
  logic [3:0]  input_channel_select_o;
  logic        channel_valid_o;
  logic        converter_enable_o;
  logic        upper_ref_pin_o;
  logic        lower_ref_pin_o;
  logic [3:0]  port_config_o;
  logic        irq_o;
  logic        small_valid;
  logic [11:0] vin = 12'h000;
  logic [31:0] rdat;
  logic        rerr;
  int          fails = 0;
  int          total_checks = 0;

  adcc_top #(.LARGE_VARIANT(1'b1)) dut (.ref_clk_i, .rst_i, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .comp_i, .dac_code_o, .sample_o,
    .input_channel_select_o, .channel_valid_o, .converter_enable_o, .upper_ref_pin_o,
    .lower_ref_pin_o, .port_config_o, .irq_o);

  // small variant beside the large one, watched for its channel map
  adcc_top #(.LARGE_VARIANT(1'b0)) dut_small (.ref_clk_i, .rst_i, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb, .prdata(), .pready(), .pslverr(), .comp_i, .dac_code_o(),
    .sample_o(), .input_channel_select_o(), .channel_valid_o(small_valid),
    .converter_enable_o(), .upper_ref_pin_o(), .lower_ref_pin_o(), .port_config_o(),
    .irq_o());

  initial
  begin
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  // ideal comparator: input at or above the trial code
  always @(posedge ref_clk_i) comp_i <= (vin >= dac_code_o);

  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk_i);
    penable <= 1'b1;
    // the wait ends once pready is seen high; the watchdog covers a slave that never answers
    do
    begin
      @(posedge ref_clk_i);
    end
    while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk_i);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, exp, rdat);
  endtask

  // start on channel 1, poll until idle, then read both result bytes
  task automatic conv(input logic [11:0] v, input logic [7:0] tim, input logic [7:0] hi,
                      input logic [7:0] lo);
    int n;
    vin = v;
    apb(1'b1, adcc_pkg::ADDR_TIM_CFG, {24'h0, tim});
    apb(1'b1, adcc_pkg::ADDR_CONTROL, 32'h7);
    chk("sampling", 32'h1, 32'(sample_o));
    rd(adcc_pkg::ADDR_CONTROL, 32'h7, "busy_bit");
    n = 0;
    do
    begin
      apb(1'b0, adcc_pkg::ADDR_CONTROL, 32'h0);
      n++;
    end
    while (rdat[1] !== 1'b0 && n < 100);
    chk("idle_bit", 32'h5, rdat);
    rd(adcc_pkg::ADDR_RES_HIGH, {24'h0, hi}, "result_high");
    rd(adcc_pkg::ADDR_RES_LOW, {24'h0, lo}, "result_low");
    chk("dac_code", {20'h0, v}, {20'h0, dac_code_o});
  endtask

  task automatic t_reset;
    rd(adcc_pkg::ADDR_CONTROL, 32'h0, "control_reset");
    chk("enable_reset", 32'h0, 32'(converter_enable_o));
    $display("test reset done");
  endtask

  task automatic t_ctrl;
    apb(1'b1, adcc_pkg::ADDR_CONTROL, 32'hFC);
    rd(adcc_pkg::ADDR_CONTROL, 32'h3C, "control_top");
    chk("channel_out", 32'hF, 32'(input_channel_select_o));
    for (int c = 0; c < 16; c++)
    begin
      apb(1'b1, adcc_pkg::ADDR_CONTROL, 32'(c * 4 + 1));
      rd(adcc_pkg::ADDR_CONTROL, 32'(c * 4 + 1), "control_chan");
      chk("channel_valid", 32'(c <= 12), 32'(channel_valid_o));
      chk("small_valid", 32'(c <= 12 && (c < 5 || c > 7)), 32'(small_valid));
    end
    apb(1'b1, adcc_pkg::ADDR_CONTROL, 32'h0);
    $display("test control done");
  endtask

  task automatic t_cfg;
    apb(1'b1, adcc_pkg::ADDR_PIN_CFG, 32'h35);
    chk("ref_pins", 32'h35, {26'h0, lower_ref_pin_o, upper_ref_pin_o, port_config_o});
    apb(1'b1, 8'h1C, 32'hFF);
    chk("slverr_write", 32'h1, 32'(rerr));
    apb(1'b0, 8'h1C, 32'h0);
    chk("slverr_read", 32'h1, 32'(rerr));
    chk("unmapped_data", 32'h0, rdat);
    apb(1'b1, adcc_pkg::ADDR_RES_LOW, 32'hFF);
    rd(adcc_pkg::ADDR_RES_LOW, 32'h0, "result_read_only");
    $display("test config done");
  endtask

  task automatic t_conv;
    apb(1'b1, adcc_pkg::ADDR_IRQ_MASK, 32'h1);
    conv(12'hA5C, 8'h80, 8'h0A, 8'h5C);
    chk("irq_done", 32'h1, 32'(irq_o));
    rd(adcc_pkg::ADDR_IRQ_STAT, 32'h1, "status_done");
    chk("irq_cleared", 32'h0, 32'(irq_o));
    apb(1'b1, adcc_pkg::ADDR_IRQ_MASK, 32'h0);
    conv(12'h3C7, 8'h00, 8'h3C, 8'h70);
    conv(12'hFFF, 8'h89, 8'h0F, 8'hFF);
    chk("irq_masked", 32'h0, 32'(irq_o));
    rd(adcc_pkg::ADDR_IRQ_STAT, 32'h1, "status_masked");
    $display("test conversion done");
  endtask

  task automatic t_abort;
    apb(1'b1, adcc_pkg::ADDR_IRQ_MASK, 32'h2);
    apb(1'b1, adcc_pkg::ADDR_CONTROL, 32'h7);
    apb(1'b1, adcc_pkg::ADDR_CONTROL, 32'h0);
    // abort status lands on the write task's closing edge, one edge after the access edge
    @(posedge ref_clk_i);
    chk("irq_abort", 32'h1, 32'(irq_o));
    rd(adcc_pkg::ADDR_CONTROL, 32'h0, "control_off");
    rd(adcc_pkg::ADDR_IRQ_STAT, 32'h2, "status_abort");
    $display("test abort done");
  endtask

  initial
  begin
    repeat (20000) @(posedge ref_clk_i);
    fails++;
    summarize;
  end

  initial
  begin
    repeat (5) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    @(posedge ref_clk_i);
    t_reset;
    t_ctrl;
    t_cfg;
    t_conv;
    t_abort;
    summarize;
  end
endmodule
`default_nettype wire
